// ==== rtl/seg_port_pkg.sv ====
// Package for the LCD-shared 8-bit port: register indices, widths,
// reset values, segment-select codes and the carrier structs.
// Assumes a single 100 MHz clock and a plain strobe register port.
package seg_port_pkg;

    localparam int unsigned PORT_W   = 8;
    localparam int unsigned ADDR_W   = 4;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned SEL_W    = 4;
    localparam int unsigned SEG_BASE = 33;

    // Register indices on the plain port
    localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_LATCH     = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PIN_STATE = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_LCD_CTRL  = 4'h3;

    localparam logic [PORT_W-1:0] LATCH_RESET     = 8'h00;
    localparam logic [PORT_W-1:0] DIRECTION_RESET = 8'h00;
    localparam logic [SEL_W-1:0]  SELECT_RESET    = 4'h0;
    localparam logic [DATA_W-1:0] UNDEF_READ      = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ   = 8'h00;

    localparam logic [SEL_W-1:0] SEL_GPIO = 4'h0;

    typedef enum logic [1:0] {
        PIN_INPUT  = 2'b00,
        PIN_OUTPUT = 2'b01,
        PIN_SEGMENT = 2'b10
    } pin_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } pin_drive_t;

endpackage : seg_port_pkg

// ==== rtl/seg_pin_sync.sv ====
// Two-flop synchroniser for the eight port pin inputs.
// Assumes pins are asynchronous to ref_clk_i.
`timescale 1ns/1ns
`default_nettype none
module seg_pin_sync (
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_i,
    input  wire logic [seg_port_pkg::PORT_W-1:0] pin_i,
    output logic      [seg_port_pkg::PORT_W-1:0] sync_o
);
    import seg_port_pkg::*;

    logic [PORT_W-1:0] meta;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta   <= LATCH_RESET;
            sync_o <= LATCH_RESET;
        end else begin
            meta   <= pin_i;
            sync_o <= meta;
        end
    end

endmodule : seg_pin_sync
`default_nettype wire

// ==== rtl/lcd_shared_gpio_port.sv ====
// Top of the 8-bit general purpose port whose pins double as LCD
// segment outputs 33 to 40. Registers sit on a plain strobe port.
// Assumes one 100 MHz clock, synchronous active-high reset, and that
// the LCD controller supplies segment levels on seg_level_i.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Eight-bit read/write output latch, reset to zero, drives GPIO outputs.
// - Pin-state read returns latch bit where direction bit is one.
// - Pin-state read returns sampled pin level where direction bit is zero.
// - Pin-state register is read-only; its reset content follows the pins.
// - Port bit n doubles as LCD segment n plus 33, segments 33 to 40.
// - Select field zero: pins are GPIO, direction bit picks in or out.
// - Select codes 0001, 001X, 010X make every pin a segment output.
// - Write-only direction bits reset to zero; one means output in GPIO.
// - Direction register reads undefined value with no side effect.
module lcd_shared_gpio_port (
    input  wire logic                                ref_clk_i,
    input  wire logic                                rst_i,
    input  wire logic [seg_port_pkg::ADDR_W-1:0]     addr_i,
    input  wire logic [seg_port_pkg::DATA_W-1:0]     wdata_i,
    input  wire logic                                wr_i,
    input  wire logic                                rd_i,
    output logic      [seg_port_pkg::DATA_W-1:0]     rdata_o,
    input  wire logic [seg_port_pkg::PORT_W-1:0]     pin_i,
    output logic      [seg_port_pkg::PORT_W-1:0]     pin_o,
    output logic      [seg_port_pkg::PORT_W-1:0]     pin_oe_o,
    input  wire logic [seg_port_pkg::PORT_W-1:0]     seg_level_i,
    output logic                                     seg_mode_o
);
    import seg_port_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg_req_t          req;
    logic [PORT_W-1:0] output_latch;
    logic [PORT_W-1:0] direction;
    logic [SEL_W-1:0]  segment_select;
    logic [PORT_W-1:0] pin_sync;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    seg_pin_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pin_i     (pin_i),
        .sync_o    (pin_sync)
    );

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    function automatic logic is_gpio(input logic [SEL_W-1:0] sel);
        is_gpio = (sel == SEL_GPIO);
    endfunction : is_gpio

    function automatic pin_mode_t pin_mode(input logic gpio,
                                           input logic dir_bit);
        if (!gpio)
            pin_mode = PIN_SEGMENT;
        else if (dir_bit)
            pin_mode = PIN_OUTPUT;
        else
            pin_mode = PIN_INPUT;
    endfunction : pin_mode

    wire gpio_active = is_gpio(segment_select);
    wire hit_dir   = (req.addr == ADDR_DIRECTION);
    wire hit_latch = (req.addr == ADDR_LATCH);
    wire hit_pins  = (req.addr == ADDR_PIN_STATE);
    wire hit_ctrl  = (req.addr == ADDR_LCD_CTRL);

    // ------------------------------------------------------------
    // Pin drive, one mode per bit
    // ------------------------------------------------------------
    pin_drive_t next_drive;

    always_comb begin
        next_drive = '0;
        for (int n = 0; n < PORT_W; n++) begin
            case (pin_mode(gpio_active, direction[n]))
                PIN_OUTPUT: begin
                    next_drive.out[n] = output_latch[n];
                    next_drive.oe[n]  = 1'b1;
                end
                PIN_SEGMENT: begin
                    // Bit n carries segment SEG_BASE + n
                    next_drive.out[n] = seg_level_i[n];
                    next_drive.oe[n]  = 1'b1;
                end
                default: begin
                    next_drive.out[n] = 1'b0;
                    next_drive.oe[n]  = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    wire [PORT_W-1:0] pin_state =
        (direction & output_latch) | (~direction & pin_sync);

    logic [DATA_W-1:0] next_rdata;
    always_comb begin
        if (hit_latch)
            next_rdata = output_latch;
        else if (hit_pins)
            next_rdata = pin_state;
        else if (hit_ctrl)
            next_rdata = {{(DATA_W-SEL_W){1'b0}}, segment_select};
        else if (hit_dir)
            next_rdata = UNDEF_READ;
        else
            next_rdata = UNMAPPED_READ;
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            output_latch   <= LATCH_RESET;
            direction      <= DIRECTION_RESET;
            segment_select <= SELECT_RESET;
        end else if (req.wr) begin
            if (hit_latch)
                output_latch <= req.wdata;
            if (hit_dir)
                direction <= req.wdata;
            if (hit_ctrl)
                segment_select <= req.wdata[SEL_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o    <= UNMAPPED_READ;
            pin_o      <= LATCH_RESET;
            pin_oe_o   <= LATCH_RESET;
            seg_mode_o <= 1'b0;
        end else begin
            rdata_o    <= req.rd ? next_rdata : UNMAPPED_READ;
            pin_o      <= next_drive.out;
            pin_oe_o   <= next_drive.oe;
            seg_mode_o <= ~gpio_active;
        end
    end

endmodule : lcd_shared_gpio_port
`default_nettype wire

// ==== bench/lcd_shared_gpio_port_properties.sv ====
// Port checker for the LCD-shared GPIO port, bound to its top.
// Assumes register indices and widths from seg_port_pkg.
`timescale 1ns/1ns
`default_nettype none
module lcd_shared_gpio_port_checker import seg_port_pkg::*; (
    input wire logic              ref_clk_i, rst_i, wr_i, rd_i, seg_mode_o,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i, rdata_o,
    input wire logic [PORT_W-1:0] pin_i, pin_o, pin_oe_o, seg_level_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_ctrl_wr; wr_i && addr_i == ADDR_LCD_CTRL; endsequence
    sequence s_dir_wr; wr_i && addr_i == ADDR_DIRECTION ##1 !wr_i; endsequence
    property p_reset_clear;
        $past(rst_i) |-> !seg_mode_o && pin_oe_o == 8'h00 && rdata_o == 8'h00;
    endproperty
    property p_idle_zero; !rd_i |=> rdata_o == 8'h00; endproperty
    property p_dir_read;
        rd_i && addr_i == ADDR_DIRECTION |=> rdata_o == UNDEF_READ;
    endproperty
    property p_seg_oe; seg_mode_o |-> pin_oe_o == 8'hff; endproperty
    property p_seg_map; seg_mode_o |-> pin_o == $past(seg_level_i); endproperty
    property p_sel_seg; s_ctrl_wr ##0 wdata_i[3:0] != 4'h0 |-> ##2 seg_mode_o;
    endproperty
    property p_sel_gpio; s_ctrl_wr ##0 wdata_i[3:0] == 4'h0 |-> ##2 !seg_mode_o;
    endproperty
    property p_dir_oe;
        s_dir_wr ##1 !seg_mode_o |-> pin_oe_o == $past(wdata_i, 2);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not clear after reset");
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data not zero when idle");
    a_dir_read: assert property (p_dir_read)
        else $error("direction read value wrong");
    a_seg_oe: assert property (p_seg_oe)
        else $error("segment mode without full drive");
    a_seg_map: assert property (p_seg_map)
        else $error("segment level not on pin");
    a_sel_seg: assert property (p_sel_seg)
        else $error("nonzero select not segment mode");
    a_sel_gpio: assert property (p_sel_gpio)
        else $error("zero select not port mode");
    a_dir_oe: assert property (p_dir_oe)
        else $error("direction bits not on enables");
endmodule : lcd_shared_gpio_port_checker
bind lcd_shared_gpio_port lcd_shared_gpio_port_checker u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
    .seg_mode_o(seg_mode_o), .addr_i(addr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .seg_level_i(seg_level_i));
`default_nettype wire

// ==== bench/seg_pin_model.sv ====
// Outside circuit on the port pins: drives its level where the port
// does not. Assumes enables are high while the port drives.
`timescale 1ns/1ns
`default_nettype none
module seg_pin_model (
    input  wire logic [7:0] drive_i, oe_i, level_i,
    output logic      [7:0] pin_o
);
    assign pin_o = (oe_i & drive_i) | (~oe_i & level_i);
endmodule : seg_pin_model
`default_nettype wire

// ==== bench/lcd_shared_gpio_port_tb.sv ====
// Self-checking bench for the LCD-shared GPIO port.
// Assumes the package, design, checker and pin model are compiled.
`timescale 1ns/1ns
`default_nettype none
module lcd_shared_gpio_port_tb;
    import seg_port_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
    logic              seg_mode_o;
    logic [ADDR_W-1:0] addr_i = 4'h0;
    logic [DATA_W-1:0] wdata_i = 8'h00, rdata_o;
    logic [PORT_W-1:0] pin_i, pin_o, pin_oe_o, ext = 8'h96, seg = 8'h1e;
    int error_cnt = 0, tests_run = 0, cyc = 0;
    initial forever #5 ref_clk_i = ~ref_clk_i;
    lcd_shared_gpio_port dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .seg_level_i(seg), .seg_mode_o(seg_mode_o));
    seg_pin_model ext_pins (.drive_i(pin_o), .oe_i(pin_oe_o),
        .level_i(ext), .pin_o(pin_i));
    task automatic conclude();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        rd_i <= 1'b1; addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
    endtask : rd
    task automatic settle();
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask : settle
    always @(posedge ref_clk_i) if (++cyc == 1000) begin
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(ADDR_LATCH, LATCH_RESET);
        rd(ADDR_DIRECTION, UNDEF_READ);
        rd(ADDR_PIN_STATE, 8'h96);
        $display("test reset and input done");
        wr(ADDR_LATCH, 8'h6c);
        wr(ADDR_DIRECTION, 8'hf0);
        rd(ADDR_PIN_STATE, 8'h66);
        settle();
        chk(pin_oe_o, 8'hf0);
        chk(pin_o & 8'hf0, 8'h60);
        @(posedge ref_clk_i) ext <= 8'h4b;
        settle();
        rd(ADDR_PIN_STATE, 8'h6b);
        wr(ADDR_PIN_STATE, 8'hff);
        rd(ADDR_LATCH, 8'h6c);
        rd(ADDR_PIN_STATE, 8'h6b);
        rd(4'h9, UNMAPPED_READ);
        $display("test port mode done");
        for (int c = 1; c < 16; c++) begin
            wr(ADDR_LCD_CTRL, 8'(c));
            seg <= ~seg;
            settle();
            chk({7'h00, seg_mode_o}, 8'h01);
            chk(pin_oe_o, 8'hff);
            chk(pin_o, seg);
        end
        wr(ADDR_LCD_CTRL, 8'h00);
        settle();
        chk({7'h00, seg_mode_o}, 8'h00);
        chk(pin_oe_o, 8'hf0);
        $display("test segment mode done");
        wr(ADDR_LCD_CTRL, 8'h05);
        @(posedge ref_clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(ADDR_LATCH, LATCH_RESET);
        chk({7'h00, seg_mode_o}, 8'h00);
        chk(pin_oe_o, 8'h00);
        chk(pin_o, 8'h00);
        $display("test mid-run reset done");
        conclude();
    end
endmodule : lcd_shared_gpio_port_tb
`default_nettype wire
